// >>> inc/hsf_pkg.sv
// Register map, field layout, reset values and source codes of the driver source block
package hsf_pkg;

  // Byte offsets on the register bus
  localparam logic [4:0] OFF_OL_FLAGS  = 5'h00;
  localparam logic [4:0] OFF_SRC_SEL   = 5'h04;
  localparam logic [4:0] OFF_DRV_CTRL  = 5'h08;
  localparam logic [4:0] OFF_SENSE_CFG = 5'h0C;
  localparam logic [4:0] OFF_IRQ_STAT  = 5'h10;
  localparam logic [4:0] OFF_IRQ_EN    = 5'h14;

  // Field positions
  localparam int N_OL        = 4;
  localparam int N_DRV       = 4;
  localparam int SRC_W       = 4;
  localparam int SENSE_W     = 2;
  localparam int OL_FLAG_LSB = 0;
  localparam int OL_MASK_LSB = 5;

  // Reset values
  localparam logic [3:0]  RST_OL_FLAGS = 4'h0;
  localparam logic [3:0]  RST_OL_MASK  = 4'h0;
  localparam logic [15:0] RST_SRC_SEL  = 16'h0000;
  localparam logic [3:0]  RST_DRV_EN   = 4'h0;
  localparam logic [7:0]  RST_SENSE    = 8'h00;
  localparam logic [3:0]  RST_IRQ      = 4'h0;

  // Driver source codes
  localparam logic [3:0] SRC_REG    = 4'h0;
  localparam logic [3:0] SRC_HV_IO_ONE  = 4'h1;
  localparam logic [3:0] SRC_HV_IO_TWO  = 4'h2;
  localparam logic [3:0] SRC_WAKE_INPUT_ONE  = 4'h3;
  localparam logic [3:0] SRC_WAKE_INPUT_TWO  = 4'h4;
  localparam logic [3:0] SRC_LV3    = 4'h5;
  localparam logic [3:0] SRC_LV4    = 4'h6;
  localparam logic [3:0] SRC_LV5    = 4'h7;
  localparam logic [3:0] SRC_TIMER_ONE = 4'h8;
  localparam logic [3:0] SRC_TIMER_TWO = 4'h9;
  localparam logic [3:0] SRC_TIMER_THREE = 4'hA;
  localparam logic [3:0] SRC_PULSE1 = 4'hB;
  localparam logic [3:0] SRC_PULSE2 = 4'hC;
  localparam logic [3:0] SRC_PULSE3 = 4'hD;

endpackage

// >>> hw/hsf_drv_mux.sv
// Source selector of one high-side driver
`timescale 1ns/1ps
module hsf_drv_mux (
  input  wire logic [3:0] sel_in,
  input  wire logic       reg_on_in,
  input  wire logic [6:0] pin_in,
  input  wire logic [2:0] timer_in,
  input  wire logic [2:0] pulse_in,
  output logic            on_out
);

  always_comb begin
    case (sel_in)
      hsf_pkg::SRC_REG:    on_out = reg_on_in;
      hsf_pkg::SRC_HV_IO_ONE:  on_out = pin_in[0];
      hsf_pkg::SRC_HV_IO_TWO:  on_out = pin_in[1];
      hsf_pkg::SRC_WAKE_INPUT_ONE:  on_out = pin_in[2];
      hsf_pkg::SRC_WAKE_INPUT_TWO:  on_out = pin_in[3];
      hsf_pkg::SRC_LV3:    on_out = pin_in[4];
      hsf_pkg::SRC_LV4:    on_out = pin_in[5];
      hsf_pkg::SRC_LV5:    on_out = pin_in[6];
      hsf_pkg::SRC_TIMER_ONE: on_out = timer_in[0];
      hsf_pkg::SRC_TIMER_TWO: on_out = timer_in[1];
      hsf_pkg::SRC_TIMER_THREE: on_out = timer_in[2];
      hsf_pkg::SRC_PULSE1: on_out = pulse_in[0];
      hsf_pkg::SRC_PULSE2: on_out = pulse_in[1];
      hsf_pkg::SRC_PULSE3: on_out = pulse_in[2];
      default:             on_out = 1'b0;
    endcase
  end

endmodule

// >>> hw/hsf_ol_bank.sv
// Open-load flags and their interrupt inhibit masks
`timescale 1ns/1ps
module hsf_ol_bank #(
  parameter int N = 4
) (
  input  wire logic          mclk_in,
  input  wire logic          rst_n_in,
  input  wire logic [N-1:0]  event_in,
  input  wire logic          wr_in,
  input  wire logic [15:0]   wdata_in,
  output logic      [N-1:0]  flags_out,
  output logic      [N-1:0]  mask_out
);

  typedef struct packed {
    logic [N-1:0] flags;
    logic [N-1:0] mask;
  } hsf_ol_st_t;

  hsf_ol_st_t st_reg;
  hsf_ol_st_t st_next;

  if (N != hsf_pkg::N_OL) begin : g_chk
    $error("hsf_ol_bank serves exactly four sources");
  end

  always_comb begin
    st_next = st_reg;
    for (int i = 0; i < N; i++) begin
      if (wr_in && wdata_in[hsf_pkg::OL_FLAG_LSB + i]) begin
        st_next.flags[i] = 1'b0;
      end
      if (event_in[i]) begin
        st_next.flags[i] = 1'b1;
      end
      if (wr_in) begin
        st_next.mask[i] = wdata_in[hsf_pkg::OL_MASK_LSB + i];
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      st_reg.flags <= hsf_pkg::RST_OL_FLAGS;
      st_reg.mask  <= hsf_pkg::RST_OL_MASK;
    end else begin
      st_reg <= st_next;
    end
  end

  assign flags_out = st_reg.flags;
  assign mask_out  = st_reg.mask;

endmodule

// >>> hw/hsf_top.sv
// Open-load flag bank and high-side driver source selection with Avalon-MM slave
//
// Behaviour
// - Open-load event sets sticky flag, bits 0-3
// - Writing one clears an open-load flag
// - Open-load flags read zero after reset
// - Inhibit mask bits 5-8 suppress open-load flag interrupts
// - Inhibit masks reset to zero
// - Four-bit selector per driver; zero means register
// - Codes 1-4 select high-voltage and wake pins
// - Codes 5-7 select low-voltage pins
// - Codes 8-10 select the three timers
// - Codes 11-13 select the three pulse generators
// - Selector clears on reset and driver fault
// - Two-bit selector pairs sensed input with driver
// - Driver enable clears on reset and fault
`timescale 1ns/1ps
module hsf_top #(
  parameter int N_DRV = 4
) (
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [4:0]  avs_address_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic [3:0]  openload_event_in,
  input  wire logic [3:0]  driver_fault_in,
  input  wire logic        hv_io_one_in,
  input  wire logic        hv_io_two_in,
  input  wire logic        wake_input_one_in,
  input  wire logic        wake_input_two_in,
  input  wire logic        lv_pin_three_in,
  input  wire logic        lv_pin_four_in,
  input  wire logic        lv_input_five_in,
  input  wire logic [2:0]  timer_in,
  input  wire logic [2:0]  pulse_gen_in,
  output logic      [3:0]  driver_on_out,
  output logic      [7:0]  sense_driver_sel_out,
  output logic             irq_out
);

  typedef struct packed {
    logic        bus_wait;
    logic [31:0] rdata;
    logic [15:0] src_sel;
    logic [3:0]  drv_en;
    logic [7:0]  sense;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_en;
    logic [3:0]  drv_on;
    logic        irq;
  } hsf_top_st_t;

  hsf_top_st_t st_reg;
  hsf_top_st_t st_next;

  logic [4:0]  addr_word;
  logic        rd_first;
  logic        rd_go;
  logic        wr_go;
  logic [31:0] rd_mux;
  logic [3:0]  ol_flags;
  logic [3:0]  ol_mask;
  logic [3:0]  mux_on;
  logic [6:0]  pins;
  logic [15:0] fault_nib;

  if (N_DRV != hsf_pkg::N_DRV) begin : g_chk
    $error("hsf_top serves exactly four drivers");
  end

  assign addr_word = {avs_address_in[4:2], 2'b00};
  assign rd_first  = avs_read_in && st_reg.bus_wait;
  assign rd_go     = avs_read_in && !st_reg.bus_wait;
  assign wr_go     = avs_write_in && !st_reg.bus_wait;
  assign pins      = {lv_input_five_in, lv_pin_four_in, lv_pin_three_in,
                      wake_input_two_in, wake_input_one_in, hv_io_two_in, hv_io_one_in};

  hsf_ol_bank #(
    .N (hsf_pkg::N_OL)
  ) u_ol (
    .mclk_in   (mclk_in),
    .rst_n_in  (rst_n_in),
    .event_in  (openload_event_in),
    .wr_in     (wr_go && (addr_word == hsf_pkg::OFF_OL_FLAGS)),
    .wdata_in  (avs_writedata_in[15:0]),
    .flags_out (ol_flags),
    .mask_out  (ol_mask)
  );

  for (genvar g = 0; g < N_DRV; g++) begin : g_drv
    assign fault_nib[4*g +: 4] = {4{driver_fault_in[g]}};
    hsf_drv_mux u_mux (
      .sel_in    (st_reg.src_sel[4*g +: 4]),
      .reg_on_in (st_reg.drv_en[g]),
      .pin_in    (pins),
      .timer_in  (timer_in),
      .pulse_in  (pulse_gen_in),
      .on_out    (mux_on[g])
    );
  end

  always_comb begin
    case (addr_word)
      hsf_pkg::OFF_OL_FLAGS:  rd_mux = {23'h0, ol_mask, 1'b0, ol_flags};
      hsf_pkg::OFF_SRC_SEL:   rd_mux = {16'h0000, st_reg.src_sel};
      hsf_pkg::OFF_DRV_CTRL:  rd_mux = {24'h000000, 1'b0, st_reg.drv_en[3], 1'b0,
                                        st_reg.drv_en[2], 1'b0, st_reg.drv_en[1],
                                        1'b0, st_reg.drv_en[0]};
      hsf_pkg::OFF_SENSE_CFG: rd_mux = {24'h000000, st_reg.sense};
      hsf_pkg::OFF_IRQ_STAT:  rd_mux = {28'h0000000, st_reg.irq_stat};
      hsf_pkg::OFF_IRQ_EN:    rd_mux = {28'h0000000, st_reg.irq_en};
      default:                rd_mux = 32'h00000000;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    // Wait one cycle, then complete the access
    st_next.bus_wait = !((avs_read_in || avs_write_in) && st_reg.bus_wait);
    if (rd_first) begin
      st_next.rdata = rd_mux;
    end
    if (wr_go) begin
      case (addr_word)
        hsf_pkg::OFF_SRC_SEL: begin
          st_next.src_sel = avs_writedata_in[15:0];
        end
        hsf_pkg::OFF_DRV_CTRL: begin
          for (int i = 0; i < N_DRV; i++) begin
            if (avs_writedata_in[2*i]) begin
              st_next.drv_en[i] = 1'b1;
            end
            if (avs_writedata_in[2*i+1]) begin
              st_next.drv_en[i] = 1'b0;
            end
          end
        end
        hsf_pkg::OFF_SENSE_CFG: begin
          st_next.sense = avs_writedata_in[7:0];
        end
        hsf_pkg::OFF_IRQ_EN: begin
          st_next.irq_en = avs_writedata_in[3:0];
        end
        default: begin
          st_next.src_sel = st_reg.src_sel;
        end
      endcase
    end
    // Read clears only the bits that were returned
    if (rd_go && (addr_word == hsf_pkg::OFF_IRQ_STAT)) begin
      st_next.irq_stat = st_reg.irq_stat & ~st_reg.rdata[3:0];
    end
    st_next.irq_stat = st_next.irq_stat | openload_event_in;
    for (int i = 0; i < N_DRV; i++) begin
      if (driver_fault_in[i]) begin
        st_next.src_sel[4*i +: 4] = hsf_pkg::SRC_REG;
        st_next.drv_en[i] = 1'b0;
      end
    end
    st_next.drv_on = mux_on & ~driver_fault_in;
    st_next.irq = (|(ol_flags & ~ol_mask)) || (|(st_reg.irq_stat & st_reg.irq_en));
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      st_reg.bus_wait <= 1'b1;
      st_reg.rdata    <= 32'h00000000;
      st_reg.src_sel  <= hsf_pkg::RST_SRC_SEL;
      st_reg.drv_en   <= hsf_pkg::RST_DRV_EN;
      st_reg.sense    <= hsf_pkg::RST_SENSE;
      st_reg.irq_stat <= hsf_pkg::RST_IRQ;
      st_reg.irq_en   <= hsf_pkg::RST_IRQ;
      st_reg.drv_on   <= 4'h0;
      st_reg.irq      <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign avs_readdata_out     = st_reg.rdata;
  assign avs_waitrequest_out  = st_reg.bus_wait;
  assign driver_on_out        = st_reg.drv_on;
  assign sense_driver_sel_out = st_reg.sense;
  assign irq_out              = st_reg.irq;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  property p_ol_set;
    (openload_event_in != 4'h0) |=>
      ((ol_flags & $past(openload_event_in)) == $past(openload_event_in));
  endproperty
  a_ol_set: assert property (p_ol_set) else $error("open-load flag not set");

  property p_ol_clear;
    (wr_go && addr_word == hsf_pkg::OFF_OL_FLAGS && avs_writedata_in[0]
      && !openload_event_in[0]) |=> !ol_flags[0];
  endproperty
  a_ol_clear: assert property (p_ol_clear) else $error("open-load flag not cleared");

  property p_ol_reset;
    $rose(rst_n_in) |-> (ol_flags == 4'h0);
  endproperty
  a_ol_reset: assert property (p_ol_reset) else $error("flags not zero after reset");

  property p_mask_reset;
    $rose(rst_n_in) |-> (ol_mask == 4'h0) && !irq_out;
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("masks not zero after reset");

  property p_irq;
    ##1 irq_out == ($past(|(ol_flags & ~ol_mask)) || $past(|(st_reg.irq_stat & st_reg.irq_en)));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt does not follow flags");

  property p_mask_inhibit;
    (ol_mask == 4'hF && st_reg.irq_en == 4'h0) [*2] |-> !irq_out;
  endproperty
  a_mask_inhibit: assert property (p_mask_inhibit) else $error("inhibited source raised irq");

  property p_fault_clear;
    (driver_fault_in != 4'h0) |=>
      ((st_reg.src_sel & $past(fault_nib)) == 16'h0000)
      && ((st_reg.drv_en & $past(driver_fault_in)) == 4'h0);
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault did not clear driver");

  property p_reg_src;
    (st_reg.src_sel[3:0] == hsf_pkg::SRC_REG && !driver_fault_in[0])
      |=> driver_on_out[0] == $past(st_reg.drv_en[0]);
  endproperty
  a_reg_src: assert property (p_reg_src) else $error("register source mismatch");

  property p_pin_src;
    (st_reg.src_sel[3:0] == hsf_pkg::SRC_HV_IO_ONE && !driver_fault_in[0])
      |=> driver_on_out[0] == $past(hv_io_one_in);
  endproperty
  a_pin_src: assert property (p_pin_src) else $error("pin source mismatch");

  property p_timer_src;
    (st_reg.src_sel[3:0] == hsf_pkg::SRC_TIMER_ONE && !driver_fault_in[0])
      |=> driver_on_out[0] == $past(timer_in[0]);
  endproperty
  a_timer_src: assert property (p_timer_src) else $error("timer source mismatch");

  property p_unused_src;
    (st_reg.src_sel[3:0] > hsf_pkg::SRC_PULSE3) |=> !driver_on_out[0];
  endproperty
  a_unused_src: assert property (p_unused_src) else $error("unused code drives driver");

  property p_bus_answer;
    (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus access not answered");

endmodule

// >>> tb/tb.sv
// Self-checking testbench of the driver source block over its Avalon-MM slave
`timescale 1ns/1ps
module tb;
  logic        mclk;
  logic        rst_n;
  logic        rd;
  logic        wr;
  logic [4:0]  ad;
  logic [31:0] wd;
  logic [31:0] rdata;
  logic        wreq;
  logic [3:0]  oe;
  logic [3:0]  flt;
  logic [12:0] sv;
  logic [3:0]  drv_on;
  logic [7:0]  sense;
  logic        irq;
  logic [31:0] q;
  int          errors;
  int          n_checks;

  hsf_top hsf_top_inst (
    .mclk_in              (mclk),
    .rst_n_in             (rst_n),
    .avs_read_in          (rd),
    .avs_write_in         (wr),
    .avs_address_in       (ad),
    .avs_writedata_in     (wd),
    .avs_readdata_out     (rdata),
    .avs_waitrequest_out  (wreq),
    .openload_event_in    (oe),
    .driver_fault_in      (flt),
    .hv_io_one_in         (sv[0]),
    .hv_io_two_in         (sv[1]),
    .wake_input_one_in    (sv[2]),
    .wake_input_two_in    (sv[3]),
    .lv_pin_three_in      (sv[4]),
    .lv_pin_four_in       (sv[5]),
    .lv_input_five_in     (sv[6]),
    .timer_in             (sv[9:7]),
    .pulse_gen_in         (sv[12:10]),
    .driver_on_out        (drv_on),
    .sense_driver_sel_out (sense),
    .irq_out              (irq)
  );

  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // One bus access, held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    rd <= ~w;
    wr <= w;
    ad <= a;
    wd <= d;
    do begin
      @(posedge mclk);
      k++;
    end while (wreq !== 1'b0 && k < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k >= 50) begin
      errors++;
      $display("[ERR] %0t bus wait timed out", $time);
      summarize();
    end
  endtask

  task automatic wrr(input logic [4:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] e, input string m);
    acc(1'b0, a, 32'h0000_0000);
    chk(q, e, m);
  endtask

  task automatic ev(input logic [3:0] v);
    @(posedge mclk);
    oe <= v;
    @(posedge mclk);
    oe <= 4'h0;
    repeat (3) @(posedge mclk);
  endtask

  task automatic settle();
    repeat (3) @(posedge mclk);
  endtask

  initial begin
    errors = 0;
    n_checks = 0;
    rst_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    ad = 5'h00;
    wd = 32'h0000_0000;
    oe = 4'h0;
    flt = 4'h0;
    sv = 13'h0000;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    for (int a = 0; a < 24; a += 4) rdc(a[4:0], 32'h0000_0000, "reset value");
    chk({27'h0, irq, drv_on}, 32'h0000_0000, "reset outputs");
    $display("test reset done");

    for (int i = 0; i < 4; i++) begin
      ev(4'h1 << i);
      rdc(5'h00, (32'h2 << i) - 32'h1, "flag set");
    end
    chk({31'h0, irq}, 32'h1, "irq on unmasked flag");
    rdc(hsf_pkg::OFF_IRQ_STAT, 32'h0000_000F, "irq status");
    rdc(hsf_pkg::OFF_IRQ_STAT, 32'h0000_0000, "irq status cleared");
    wrr(5'h00, 32'h0000_0001);
    rdc(5'h00, 32'h0000_000E, "write one clears");
    wrr(5'h00, 32'hFFFF_FFFF);
    rdc(5'h00, 32'h0000_01E0, "masks and unused");
    settle();
    chk({31'h0, irq}, 32'h0, "irq after clear");
    ev(4'hF);
    rdc(5'h00, 32'h0000_01EF, "masked flags");
    chk({31'h0, irq}, 32'h0, "masked irq");
    wrr(5'h00, 32'h0000_002F);
    settle();
    chk({31'h0, irq}, 32'h0, "flags cleared irq");
    ev(4'h1);
    chk({31'h0, irq}, 32'h0, "source one masked");
    ev(4'h2);
    chk({31'h0, irq}, 32'h1, "source two unmasked");
    $display("test openload done");

    for (int i = 0; i < 4; i++) begin
      for (int c = 1; c < 16; c++) begin
        wrr(hsf_pkg::OFF_SRC_SEL, 32'(c) << (4 * i));
        @(posedge mclk);
        sv <= (c < 14) ? (13'h1 << (c - 1)) : 13'h1FFF;
        settle();
        chk({28'h0, drv_on}, (c < 14) ? (32'h1 << i) : 32'h0, "source high");
        @(posedge mclk);
        sv <= (c < 14) ? ~(13'h1 << (c - 1)) : 13'h0000;
        settle();
        chk({28'h0, drv_on}, 32'h0, "source low");
      end
    end
    rdc(hsf_pkg::OFF_SRC_SEL, 32'h0000_F000, "selector readback");
    wrr(hsf_pkg::OFF_SRC_SEL, 32'h0000_0000);
    $display("test sources done");

    wrr(hsf_pkg::OFF_DRV_CTRL, 32'h0000_0055);
    rdc(hsf_pkg::OFF_DRV_CTRL, 32'h0000_0055, "enables set");
    settle();
    chk({28'h0, drv_on}, 32'h0000_000F, "register source");
    wrr(hsf_pkg::OFF_DRV_CTRL, 32'h0000_0002);
    rdc(hsf_pkg::OFF_DRV_CTRL, 32'h0000_0054, "disable bit");
    settle();
    chk({28'h0, drv_on}, 32'h0000_000E, "driver one off");
    wrr(hsf_pkg::OFF_SRC_SEL, 32'h0000_ABCD);
    @(posedge mclk);
    flt <= 4'h4;
    repeat (2) @(posedge mclk);
    flt <= 4'h0;
    rdc(hsf_pkg::OFF_SRC_SEL, 32'h0000_A0CD, "fault clears selector");
    rdc(hsf_pkg::OFF_DRV_CTRL, 32'h0000_0044, "fault clears enable");
    $display("test control done");

    wrr(hsf_pkg::OFF_SENSE_CFG, 32'h0000_00E4);
    rdc(hsf_pkg::OFF_SENSE_CFG, 32'h0000_00E4, "sense pairing");
    chk({24'h0, sense}, 32'h0000_00E4, "sense output");
    wrr(5'h18, 32'hFFFF_FFFF);
    rdc(5'h18, 32'h0000_0000, "unmapped");
    wrr(5'h00, 32'h0000_01EF);
    rdc(hsf_pkg::OFF_IRQ_STAT, 32'h0000_000F, "status sticky");
    wrr(hsf_pkg::OFF_IRQ_EN, 32'h0000_0004);
    rdc(hsf_pkg::OFF_IRQ_EN, 32'h0000_0004, "irq enable");
    ev(4'h8);
    chk({31'h0, irq}, 32'h0, "disabled status");
    ev(4'h4);
    chk({31'h0, irq}, 32'h1, "enabled status");
    rdc(hsf_pkg::OFF_IRQ_STAT, 32'h0000_000C, "status bits");
    settle();
    chk({31'h0, irq}, 32'h0, "status read clears");
    $display("test misc done");

    // Reset in mid-run with state loaded
    ev(4'hF);
    chk({31'h0, irq}, 32'h1, "irq before reset");
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    for (int a = 0; a < 24; a += 4) rdc(a[4:0], 32'h0000_0000, "reset again");
    chk({27'h0, irq, drv_on}, 32'h0000_0000, "outputs after reset");
    chk({24'h0, sense}, 32'h0000_0000, "sense after reset");
    $display("test reset again done");
    summarize();
  end
endmodule
